// ==== verilog/rps_pkg.sv ====
// Constants, pin sample indices and state encoding for the reduced-interface pin block.
// Assumes a single 100 MHz system clock with a synchronous, active-high reset.
// Notes on behaviour
// - Address bit 0 taken from strap pin.
// - Address bit 1 taken from strap pin.
// - Address bit 2 taken from receive bit-1 pin.
// - Duplex setting taken from receive bit-0 pin.
// - High mode bit from carrier/valid pin.
// - Low mode bit from dedicated strap.
// - Broadcast disable taken from reference clock pin.
// - Isolate setting taken from receive error pin.
// - Active-low test tree from interrupt pin.
// - Slow clock mode: drive 50 MHz reference.
// - Fast clock mode: reference pin left undriven.
// - Management data moves with management clock.
// - Management data pin only pulls low.
// - Interrupt pin is open-drain, low when active.
// - Two receive bits driven after reset.
// - Carrier/valid driven after reset.
// - Receive error driven after reset.
// - Shared pins inputs in reset; receive pins outputs after.
// - Upper two address bits are zero.
// - Address zero broadcast unless disabled.
`default_nettype none
package rps_pkg;

  typedef enum logic [1:0] {
    RPS_ST_STRAP = 2'h1,
    RPS_ST_RUN   = 2'h2
  } rps_state_e;

  // Index of each pin within the synchronised sample vector.
  localparam int RPS_SI_ADDR0  = 0;
  localparam int RPS_SI_ADDR1  = 1;
  localparam int RPS_SI_RXD1   = 2;
  localparam int RPS_SI_RXD0   = 3;
  localparam int RPS_SI_CRSDV  = 4;
  localparam int RPS_SI_REFCLK = 5;
  localparam int RPS_SI_RXER   = 6;
  localparam int RPS_SI_IRQ    = 7;
  localparam int RPS_SI_CFGLO  = 8;
  localparam int RPS_SI_CLKIN  = 9;
  localparam int RPS_SI_TXEN   = 10;
  localparam int RPS_SI_TXD0   = 11;
  localparam int RPS_SI_TXD1   = 12;
  localparam int RPS_SI_MDC    = 13;
  localparam int RPS_SI_MDIO   = 14;
  localparam int RPS_SYNC_W    = 15;

  localparam int RPS_ADDR_W = 5;
  localparam logic [1:0] RPS_ADDR_UPPER = 2'h0;
  localparam logic [4:0] RPS_ADDR_RST   = 5'h00;
  localparam logic [4:0] RPS_ADDR_BCAST = 5'h00;
  localparam logic       RPS_BIT_RST    = 1'h0;
  localparam logic       RPS_TTREE_RST  = 1'h1;

  // Reference clock derivation from the system clock.
  localparam int RPS_SYS_CLK_MHZ = 100;
  localparam int RPS_REF_CLK_MHZ = 50;
  localparam int RPS_REF_HALF_CYC = RPS_SYS_CLK_MHZ / (2 * RPS_REF_CLK_MHZ);
  localparam logic [1:0] RPS_REF_HALF_LAST = 2'(RPS_REF_HALF_CYC - 1);
  localparam logic [1:0] RPS_CNT_RST = 2'h0;
  localparam logic [1:0] RPS_CNT_ONE = 2'h1;

endpackage
`default_nettype wire

// ==== verilog/rps_sync2.sv ====
// Two-stage synchroniser for a vector of independent pin levels.
// Assumes each bit is a slow level; no bus coherence is implied across bits.
`timescale 1ns/1ps
`default_nettype none
module rps_sync2 #(
  parameter int W = 1
) (
  // Clock
  input  wire logic         clk_sys,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // No reset, so the pins are sampled while reset is held and straps are ready at release.
  always_ff @(posedge clk_sys) begin
    meta_reg <= d;
    q        <= meta_reg;
  end

endmodule
`default_nettype wire

// ==== verilog/rps_pin_strap.sv ====
// Shared strap and reduced-interface pins: strap capture, reference clock, link pins.
// Assumes the core logic on clk_sys supplies receive data, interrupt and management bits.
`timescale 1ns/1ps
`default_nettype none
module rps_pin_strap
  import rps_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Clock mode select, high for an external 50 MHz clock
  input  wire logic       clk_mode_50,
  // Strap-only pins
  input  wire logic       addr_strap_bit0_i,
  input  wire logic       addr_strap_bit1_i,
  input  wire logic       mode_cfg_bit_lo_i,
  // Shared receive pins
  input  wire logic [1:0] rxd_i,
  output logic      [1:0] rxd_o,
  output logic            rxd_oe,
  input  wire logic       crs_dv_i,
  output logic            crs_dv_o,
  output logic            crs_dv_oe,
  input  wire logic       rx_err_i,
  output logic            rx_err_o,
  output logic            rx_err_oe,
  // Shared reference clock pin and clock input
  input  wire logic       ref_clk_i,
  output logic            ref_clk_o,
  output logic            ref_clk_oe,
  input  wire logic       clk_in,
  // Shared interrupt pin
  input  wire logic       irq_out_n_i,
  output logic            irq_out_n_o,
  output logic            irq_out_n_oe,
  // Transmit pins
  input  wire logic       tx_en_i,
  input  wire logic       txd0_i,
  input  wire logic       txd1_i,
  // Management pins
  input  wire logic       mdc_i,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe,
  // Core side receive and control
  input  wire logic [1:0] rx_data,
  input  wire logic       rx_dv,
  input  wire logic       rx_err,
  input  wire logic       irq_req,
  input  wire logic       mdio_tx_bit,
  input  wire logic       mdio_tx_en,
  input  wire logic [4:0] mgmt_req_addr,
  // Captured straps
  output logic      [4:0] mgmt_station_address,
  output logic            duplex_cfg,
  output logic            mode_cfg_bit_hi,
  output logic            mode_cfg_bit_lo,
  output logic            bcast_addr_disable,
  output logic            isolate_cfg,
  output logic            test_tree_en,
  output logic            strap_done,
  // Core side transmit and management
  output logic            tx_frame_en,
  output logic      [1:0] tx_data,
  output logic            tx_strobe,
  output logic            mdio_rx_bit,
  output logic            mdio_rx_strobe,
  output logic            mgmt_addr_hit
);

  logic [RPS_SYNC_W-1:0] pin_raw;
  logic [RPS_SYNC_W-1:0] pin_q;

  // Bit positions follow the sample indices, highest index first.
  assign pin_raw = {mdio_i, mdc_i, txd1_i, txd0_i, tx_en_i, clk_in, mode_cfg_bit_lo_i,
                    irq_out_n_i, rx_err_i, ref_clk_i, crs_dv_i, rxd_i[0], rxd_i[1],
                    addr_strap_bit1_i, addr_strap_bit0_i};

  rps_sync2 #(
    .W (RPS_SYNC_W)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .d       (pin_raw),
    .q       (pin_q)
  );

  // Strap capture group.
  rps_state_e st_reg, st_next;
  logic [4:0] addr_reg, addr_next;
  logic       dup_reg, dup_next;
  logic       cfg_hi_reg, cfg_hi_next;
  logic       cfg_lo_reg, cfg_lo_next;
  logic       bcd_reg, bcd_next;
  logic       iso_reg, iso_next;
  logic       tt_reg, tt_next;
  logic       run;

  always_comb begin
    st_next     = st_reg;
    addr_next   = addr_reg;
    dup_next    = dup_reg;
    cfg_hi_next = cfg_hi_reg;
    cfg_lo_next = cfg_lo_reg;
    bcd_next    = bcd_reg;
    iso_next    = iso_reg;
    tt_next     = tt_reg;
    case (st_reg)
      RPS_ST_STRAP: begin
        // The first cycle out of reset still sees pin levels sampled with all drivers off.
        addr_next   = {RPS_ADDR_UPPER,
                       pin_q[RPS_SI_RXD1],
                       pin_q[RPS_SI_ADDR1],
                       pin_q[RPS_SI_ADDR0]};
        dup_next    = pin_q[RPS_SI_RXD0];
        cfg_hi_next = pin_q[RPS_SI_CRSDV];
        cfg_lo_next = pin_q[RPS_SI_CFGLO];
        bcd_next    = pin_q[RPS_SI_REFCLK];
        iso_next    = pin_q[RPS_SI_RXER];
        tt_next     = ~pin_q[RPS_SI_IRQ];
        st_next     = RPS_ST_RUN;
      end
      RPS_ST_RUN: begin
        st_next = RPS_ST_RUN;
      end
      default: begin
        st_next = RPS_ST_STRAP;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg     <= RPS_ST_STRAP;
      addr_reg   <= RPS_ADDR_RST;
      dup_reg    <= RPS_BIT_RST;
      cfg_hi_reg <= RPS_BIT_RST;
      cfg_lo_reg <= RPS_BIT_RST;
      bcd_reg    <= RPS_BIT_RST;
      iso_reg    <= RPS_BIT_RST;
      tt_reg     <= RPS_TTREE_RST;
    end else begin
      st_reg     <= st_next;
      addr_reg   <= addr_next;
      dup_reg    <= dup_next;
      cfg_hi_reg <= cfg_hi_next;
      cfg_lo_reg <= cfg_lo_next;
      bcd_reg    <= bcd_next;
      iso_reg    <= iso_next;
      tt_reg     <= tt_next;
    end
  end

  assign run                  = (st_reg == RPS_ST_RUN);
  assign strap_done           = run;
  assign mgmt_station_address = addr_reg;
  assign duplex_cfg           = dup_reg;
  assign mode_cfg_bit_hi      = cfg_hi_reg;
  assign mode_cfg_bit_lo      = cfg_lo_reg;
  assign bcast_addr_disable   = bcd_reg;
  assign isolate_cfg          = iso_reg;
  assign test_tree_en         = tt_reg;

  // Reference clock group.
  logic [1:0] div_cnt_reg, div_cnt_next;
  logic       ref_lvl_reg, ref_lvl_next;
  logic       clkin_prev_reg;
  logic       ref_rise;

  always_comb begin
    if (div_cnt_reg == RPS_REF_HALF_LAST) begin
      div_cnt_next = RPS_CNT_RST;
      ref_lvl_next = ~ref_lvl_reg;
    end else begin
      div_cnt_next = div_cnt_reg + RPS_CNT_ONE;
      ref_lvl_next = ref_lvl_reg;
    end
    // An external clock is only seen through the synchroniser, so it must run well below clk_sys.
    if (clk_mode_50) begin
      ref_rise = pin_q[RPS_SI_CLKIN] & ~clkin_prev_reg;
    end else begin
      ref_rise = (div_cnt_reg == RPS_REF_HALF_LAST) & ~ref_lvl_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_cnt_reg    <= RPS_CNT_RST;
      ref_lvl_reg    <= RPS_BIT_RST;
      clkin_prev_reg <= RPS_BIT_RST;
    end else begin
      div_cnt_reg    <= div_cnt_next;
      ref_lvl_reg    <= ref_lvl_next;
      clkin_prev_reg <= pin_q[RPS_SI_CLKIN];
    end
  end

  assign ref_clk_o  = ref_lvl_reg;
  assign ref_clk_oe = run & ~clk_mode_50;

  // Link group: receive launch, transmit sample, management and interrupt.
  logic [1:0] rxd_reg, rxd_next;
  logic       crs_reg, crs_next;
  logic       rxer_reg, rxer_next;
  logic       txen_reg, txen_next;
  logic [1:0] txd_reg, txd_next;
  logic       txs_reg, txs_next;
  logic       mdc_prev_reg, mdc_rise;
  logic       mrx_reg, mrx_next;
  logic       mrs_reg, mrs_next;
  logic       mdrv_reg, mdrv_next;
  logic       irq_reg;
  logic       hit_reg, hit_next;

  always_comb begin
    rxd_next  = rxd_reg;
    crs_next  = crs_reg;
    rxer_next = rxer_reg;
    txen_next = txen_reg;
    txd_next  = txd_reg;
    txs_next  = 1'h0;
    mrx_next  = mrx_reg;
    mrs_next  = 1'h0;
    mdrv_next = mdrv_reg;
    mdc_rise  = pin_q[RPS_SI_MDC] & ~mdc_prev_reg;
    if (ref_rise && run) begin
      rxd_next  = rx_data;
      crs_next  = rx_dv;
      rxer_next = rx_err;
      txen_next = pin_q[RPS_SI_TXEN];
      txd_next  = {pin_q[RPS_SI_TXD1], pin_q[RPS_SI_TXD0]};
      txs_next  = 1'h1;
    end
    if (mdc_rise && run) begin
      mrx_next  = pin_q[RPS_SI_MDIO];
      mrs_next  = 1'h1;
      mdrv_next = mdio_tx_en & ~mdio_tx_bit;
    end
    // Address zero answers every station unless the broadcast strap was high.
    hit_next = run & ((mgmt_req_addr == addr_reg) |
               ((mgmt_req_addr == RPS_ADDR_BCAST) & ~bcd_reg));
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxd_reg      <= RPS_CNT_RST;
      crs_reg      <= RPS_BIT_RST;
      rxer_reg     <= RPS_BIT_RST;
      txen_reg     <= RPS_BIT_RST;
      txd_reg      <= RPS_CNT_RST;
      txs_reg      <= RPS_BIT_RST;
      mdc_prev_reg <= RPS_BIT_RST;
      mrx_reg      <= RPS_BIT_RST;
      mrs_reg      <= RPS_BIT_RST;
      mdrv_reg     <= RPS_BIT_RST;
      irq_reg      <= RPS_BIT_RST;
      hit_reg      <= RPS_BIT_RST;
    end else begin
      rxd_reg      <= rxd_next;
      crs_reg      <= crs_next;
      rxer_reg     <= rxer_next;
      txen_reg     <= txen_next;
      txd_reg      <= txd_next;
      txs_reg      <= txs_next;
      mdc_prev_reg <= pin_q[RPS_SI_MDC];
      mrx_reg      <= mrx_next;
      mrs_reg      <= mrs_next;
      mdrv_reg     <= mdrv_next;
      irq_reg      <= irq_req & run;
      hit_reg      <= hit_next;
    end
  end

  // Outputs stay off through reset so the external pulls set the strap levels.
  assign rxd_o          = rxd_reg;
  assign rxd_oe         = run;
  assign crs_dv_o       = crs_reg;
  assign crs_dv_oe      = run;
  assign rx_err_o       = rxer_reg;
  assign rx_err_oe      = run;
  assign irq_out_n_o    = 1'h0;
  assign irq_out_n_oe   = run & irq_reg;
  assign mdio_o         = 1'h0;
  assign mdio_oe        = run & mdrv_reg;
  assign tx_frame_en    = txen_reg;
  assign tx_data        = txd_reg;
  assign tx_strobe      = txs_reg;
  assign mdio_rx_bit    = mrx_reg;
  assign mdio_rx_strobe = mrs_reg;
  assign mgmt_addr_hit  = hit_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_addr_bit0_cap: assert property (st_reg == RPS_ST_STRAP |=>
    addr_reg[0] == $past(pin_q[RPS_SI_ADDR0])) else $error("address bit 0 not captured");
  a_addr_bit1_cap: assert property (st_reg == RPS_ST_STRAP |=>
    addr_reg[1] == $past(pin_q[RPS_SI_ADDR1])) else $error("address bit 1 not captured");
  a_addr_bit2_cap: assert property (st_reg == RPS_ST_STRAP |=>
    addr_reg[2] == $past(pin_q[RPS_SI_RXD1])) else $error("address bit 2 not captured");
  a_cfg_pins_cap: assert property (st_reg == RPS_ST_STRAP |=>
    dup_reg == $past(pin_q[RPS_SI_RXD0]) && cfg_hi_reg == $past(pin_q[RPS_SI_CRSDV])
    && cfg_lo_reg == $past(pin_q[RPS_SI_CFGLO])) else $error("config straps wrong");
  a_ttree_inv_cap: assert property (st_reg == RPS_ST_STRAP |=>
    tt_reg != $past(pin_q[RPS_SI_IRQ]) && iso_reg == $past(pin_q[RPS_SI_RXER])
    && bcd_reg == $past(pin_q[RPS_SI_REFCLK])) else $error("test or isolate strap wrong");
  a_straps_held: assert property (run && $past(run) |->
    $stable(addr_reg) && $stable({dup_reg, cfg_hi_reg, cfg_lo_reg, bcd_reg, iso_reg, tt_reg}))
    else $error("strap value changed after capture");
  a_addr_upper_zero: assert property (addr_reg[4:3] == RPS_ADDR_UPPER)
    else $error("upper address bits not zero");
  a_pins_off_strap: assert property (!run |->
    !rxd_oe && !crs_dv_oe && !rx_err_oe && !ref_clk_oe && !irq_out_n_oe && !mdio_oe)
    else $error("pin driven during strap phase");
  a_ref_toggles: assert property (run && !clk_mode_50 |->
    ref_clk_oe && ref_clk_o != $past(ref_clk_o, 1) ##1 ref_clk_o == $past(ref_clk_o, 2))
    else $error("reference clock not at half rate");
  a_ref_undriven: assert property (clk_mode_50 |-> !ref_clk_oe)
    else $error("reference pin driven in external clock mode");
  a_rx_launch: assert property (ref_rise && run |=>
    rxd_o == $past(rx_data) && crs_dv_o == $past(rx_dv) && rx_err_o == $past(rx_err))
    else $error("receive pins not launched on reference rise");
  a_mdio_od: assert property (mdio_oe |-> !mdio_o && mdrv_reg)
    else $error("management data driven high");
  a_irq_od: assert property (irq_req && run ##1 run |-> irq_out_n_oe && !irq_out_n_o)
    else $error("interrupt not pulled low");
  a_bcast_hit: assert property (run && mgmt_req_addr == RPS_ADDR_BCAST |=>
    mgmt_addr_hit == ($past(!bcd_reg) || $past(addr_reg) == RPS_ADDR_BCAST))
    else $error("broadcast address decode wrong");

  c_strap_capture: cover property (st_reg == RPS_ST_STRAP ##1 run);
  c_bcast_used:    cover property (mgmt_addr_hit && mgmt_req_addr == RPS_ADDR_BCAST);
  c_tx_frame:      cover property (tx_strobe && tx_frame_en);
  c_mdio_rx:       cover property (mdio_rx_strobe ##[1:20] mdio_oe);

endmodule
`default_nettype wire

// ==== dv/rps_mac_model.sv ====
// Behavioural model of the MAC and station management controller beside the pin block.
// Assumes the bench resolves the open-drain data line and picks the reference clock it sees.
`timescale 1ns/1ps
`default_nettype none
module rps_mac_model (
  // Reference and mode
  input  wire logic ref_clk,
  input  wire logic ext_clk_on,
  // Pins toward the device
  output logic      clk_in,
  output logic      tx_en,
  output logic      txd0,
  output logic      txd1,
  output logic      mdc,
  output logic      mdio_pull_low
);
  initial begin
    clk_in = 1'b0;
    tx_en = 1'b0;
    txd0 = 1'b0;
    txd1 = 1'b0;
    mdc = 1'b0;
    mdio_pull_low = 1'b0;
    // The offset keeps these edges clear of the system clock's rising edges.
    #3;
    forever begin
      #62.5;
      clk_in = ext_clk_on ? ~clk_in : 1'b0;
    end
  end

  task automatic send_tx(input logic en, input logic [1:0] d);
    @(posedge ref_clk);
    tx_en <= en;
    txd0  <= d[0];
    txd1  <= d[1];
  endtask

  // The management clock stands still between bursts, as a real controller's does.
  task automatic mdc_burst(input int n, input logic low);
    mdio_pull_low = low;
    repeat (n) begin
      #62.5 mdc = 1'b1;
      #62.5 mdc = 1'b0;
    end
    mdio_pull_low = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_rmii_pin_strap_interface.sv ====
// Self-checking bench for the shared strap and reduced-interface pin block.
// Assumes the design's own assertions run alongside; pins resolve here from pulls and enables.
`timescale 1ns/1ps
`default_nettype none
module tb_rmii_pin_strap_interface;
  import rps_pkg::*;
  logic clk_sys, rst, clk_mode_50;
  logic [8:0] strap_pins;
  logic [1:0] rx_data, rxd_o, tx_data;
  logic rx_dv, rx_err, irq_req, mdio_tx_bit, mdio_tx_en;
  logic [4:0] mgmt_req_addr, mgmt_station_address;
  logic rxd_oe, crs_dv_o, crs_dv_oe, rx_err_o, rx_err_oe, ref_clk_o, ref_clk_oe;
  logic irq_out_n_o, irq_out_n_oe, mdio_o, mdio_oe, duplex_cfg, mode_cfg_bit_hi;
  logic mode_cfg_bit_lo, bcast_addr_disable, isolate_cfg, test_tree_en, strap_done;
  logic tx_frame_en, tx_strobe, mdio_rx_bit, mdio_rx_strobe, mgmt_addr_hit;
  logic clk_in, tx_en, txd0, txd1, mdc, mac_low;
  int miscompares = 0;
  int comparisons = 0;
  int n_strobe;
  // Rows: pin levels {irq,rxer,ref,cfglo,crsdv,rxd0,rxd1,a1,a0}, then expected straps.
  logic [19:0] rows [4] = '{{9'h000, 11'h400}, {9'h1ff, 11'h3e7},
                            {9'h155, 11'h145}, {9'h0aa, 11'h6a2}};

  rps_pin_strap u_rps_pin_strap (
    .clk_sys(clk_sys), .rst(rst), .clk_mode_50(clk_mode_50),
    .addr_strap_bit0_i(strap_pins[0]), .addr_strap_bit1_i(strap_pins[1]),
    .mode_cfg_bit_lo_i(strap_pins[5]),
    .rxd_i(rxd_oe ? rxd_o : {strap_pins[2], strap_pins[3]}), .rxd_o(rxd_o), .rxd_oe(rxd_oe),
    .crs_dv_i(crs_dv_oe ? crs_dv_o : strap_pins[4]), .crs_dv_o(crs_dv_o), .crs_dv_oe(crs_dv_oe),
    .rx_err_i(rx_err_oe ? rx_err_o : strap_pins[7]), .rx_err_o(rx_err_o), .rx_err_oe(rx_err_oe),
    .ref_clk_i(ref_clk_oe ? ref_clk_o : strap_pins[6]), .ref_clk_o(ref_clk_o),
    .ref_clk_oe(ref_clk_oe), .clk_in(clk_in),
    .irq_out_n_i(irq_out_n_oe ? irq_out_n_o : strap_pins[8]), .irq_out_n_o(irq_out_n_o),
    .irq_out_n_oe(irq_out_n_oe), .tx_en_i(tx_en), .txd0_i(txd0), .txd1_i(txd1),
    .mdc_i(mdc), .mdio_i(~((mdio_oe & ~mdio_o) | mac_low)), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .rx_data(rx_data), .rx_dv(rx_dv), .rx_err(rx_err), .irq_req(irq_req),
    .mdio_tx_bit(mdio_tx_bit), .mdio_tx_en(mdio_tx_en), .mgmt_req_addr(mgmt_req_addr),
    .mgmt_station_address(mgmt_station_address), .duplex_cfg(duplex_cfg),
    .mode_cfg_bit_hi(mode_cfg_bit_hi), .mode_cfg_bit_lo(mode_cfg_bit_lo),
    .bcast_addr_disable(bcast_addr_disable), .isolate_cfg(isolate_cfg),
    .test_tree_en(test_tree_en), .strap_done(strap_done), .tx_frame_en(tx_frame_en),
    .tx_data(tx_data), .tx_strobe(tx_strobe), .mdio_rx_bit(mdio_rx_bit),
    .mdio_rx_strobe(mdio_rx_strobe), .mgmt_addr_hit(mgmt_addr_hit)
  );

  rps_mac_model u_rps_mac_model (
    .ref_clk(clk_mode_50 ? clk_in : ref_clk_o), .ext_clk_on(clk_mode_50), .clk_in(clk_in),
    .tx_en(tx_en), .txd0(txd0), .txd1(txd1), .mdc(mdc), .mdio_pull_low(mac_low)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check_vec(input string what, input logic [10:0] exp, input logic [10:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    check_vec(what, {10'h000, exp}, {10'h000, got});
  endtask

  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic count_strobes(input int n, input bit mdio_side);
    n_strobe = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      n_strobe += mdio_side ? int'(mdio_rx_strobe) : int'(tx_strobe);
    end
  endtask

  initial begin
    rst = 1'b1;
    clk_mode_50 = 1'b0;
    strap_pins = 9'h000;
    rx_data = 2'h0;
    rx_dv = 1'b0;
    rx_err = 1'b0;
    irq_req = 1'b0;
    mdio_tx_bit = 1'b1;
    mdio_tx_en = 1'b0;
    mgmt_req_addr = 5'h1f;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      rst <= 1'b1;
      strap_pins <= rows[i][19:11];
      ticks(8);
      check_vec("oe_in_reset", 11'h000, {rxd_oe, crs_dv_oe, rx_err_oe, irq_out_n_oe});
      rst <= 1'b0;
      ticks(2);
      check_vec("oe_after", 11'h007, {rxd_oe, crs_dv_oe, rx_err_oe});
      check_vec("straps", rows[i][10:0], {test_tree_en, isolate_cfg, bcast_addr_disable,
        mode_cfg_bit_lo, mode_cfg_bit_hi, duplex_cfg, mgmt_station_address});
      strap_pins <= ~rows[i][19:11];
      mgmt_req_addr <= 5'h00;
      ticks(3);
      check_vec("straps_held", rows[i][10:0], {test_tree_en, isolate_cfg, bcast_addr_disable,
        mode_cfg_bit_lo, mode_cfg_bit_hi, duplex_cfg, mgmt_station_address});
      check_bit("hit_zero", ~rows[i][8] | (rows[i][4:0] == 5'h00), mgmt_addr_hit);
      mgmt_req_addr <= rows[i][4:0];
      ticks(2);
      check_bit("hit_own", 1'b1, mgmt_addr_hit);
      mgmt_req_addr <= rows[i][4:0] ^ 5'h10;
      ticks(2);
      check_bit("hit_upper", 1'b0, mgmt_addr_hit);
      $display("strap row %0d done", i);
    end
    rx_data <= 2'h2;
    rx_dv <= 1'b1;
    rx_err <= 1'b1;
    u_rps_mac_model.send_tx(1'b1, 2'h2);
    ticks(6);
    check_vec("rx_pins", 11'h00b, {rxd_o, crs_dv_o, rx_err_o});
    check_vec("tx_sample", 11'h006, {tx_frame_en, tx_data});
    check_bit("ref_oe_25", 1'b1, ref_clk_oe);
    count_strobes(20, 1'b0);
    check_vec("ref_rises_25", 11'd10, 11'(n_strobe));
    $display("reference test 25 done");
    clk_mode_50 <= 1'b1;
    ticks(40);
    check_bit("ref_oe_50", 1'b0, ref_clk_oe);
    count_strobes(100, 1'b0);
    check_vec("ref_rises_50", 11'd8, 11'(n_strobe));
    $display("reference test 50 done");
    mdio_tx_en <= 1'b1;
    mdio_tx_bit <= 1'b0;
    fork
      u_rps_mac_model.mdc_burst(8, 1'b0);
      count_strobes(110, 1'b1);
    join
    check_vec("mdc_rises", 11'd8, 11'(n_strobe));
    check_vec("mdio_low", 11'h004, {mdio_oe, mdio_o, mdio_rx_bit});
    mdio_tx_bit <= 1'b1;
    u_rps_mac_model.mdc_burst(2, 1'b0);
    ticks(6);
    check_vec("mdio_release", 11'h001, {mdio_oe, mdio_o, mdio_rx_bit});
    u_rps_mac_model.mdc_burst(2, 1'b1);
    ticks(6);
    check_vec("mdio_mac_low", 11'h000, {mdio_oe, mdio_o, mdio_rx_bit});
    $display("management test done");
    irq_req <= 1'b1;
    ticks(2);
    check_vec("irq_on", 11'h002, {irq_out_n_oe, irq_out_n_o});
    irq_req <= 1'b0;
    ticks(2);
    check_bit("irq_off", 1'b0, irq_out_n_oe);
    $display("interrupt test done");
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule
`default_nettype wire
